// >>> hw/sidr_pkg.sv
// sidr_pkg: offsets, field positions, reset values and carriers for the
// lane slice input delay register bank.
// assumes: shared by the bank top and its per-slice delay engine.
package sidr_pkg;

  // register indices; word offsets, not byte offsets, so byte addr = 4*index
  localparam logic [7:0] SIDR_IDX_SLICE3 = 8'h15;
  localparam logic [7:0] SIDR_IDX_SLICE4 = 8'h16;
  localparam logic [7:0] SIDR_IDX_COARSE_STEP = 8'h20;
  localparam logic [7:0] SIDR_IDX_FABRIC_CTRL = 8'h21;

  localparam int SIDR_DLY_W = 9;
  localparam int SIDR_DLY_LSB = 0;
  localparam int SIDR_COARSE_BIT = 13;
  localparam int SIDR_DOWN_BIT = 14;
  localparam int SIDR_UP_BIT = 15;
  localparam int SIDR_BUS_LO_SLICE3 = 27;
  localparam int SIDR_BUS_LO_SLICE4 = 36;
  localparam int SIDR_BUS_W = 45;

  localparam logic [8:0] SIDR_DLY_RESET = 9'h000;
  localparam logic [8:0] SIDR_DLY_MAX = 9'h1ff;
  localparam logic [8:0] SIDR_COARSE_RESET = 9'h008;
  localparam logic [8:0] SIDR_ONE_TAP = 9'h001;
  localparam logic [31:0] SIDR_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    SIDR_CMD_LOAD0 = 3'b000,
    SIDR_CMD_UP = 3'b001,
    SIDR_CMD_DOWN = 3'b010,
    SIDR_CMD_LOAD3 = 3'b011,
    SIDR_CMD_LOAD4 = 3'b100,
    SIDR_CMD_CUP = 3'b101,
    SIDR_CMD_CDOWN = 3'b110,
    SIDR_CMD_LOAD7 = 3'b111
  } sidr_cmd_e;

  // one update request into a slice delay engine
  typedef struct packed {
    logic valid;
    sidr_cmd_e cmd;
    logic [8:0] value;
  } sidr_req_s;

endpackage : sidr_pkg

// >>> hw/sidr_delay_engine.sv
// sidr_delay_engine: one slice input delay value and its update arithmetic.
// assumes: requests come from the bank on the same clock, one cycle per bus write, every cycle that a fabric load is held.
`timescale 1ns/100ps
`default_nettype none
module sidr_delay_engine
  import sidr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sidr_req_s req_i,
  input wire logic [8:0] coarse_step_i,
  output logic [8:0] delay_o
);

  logic [8:0] delay_reg;
  logic [8:0] delay_next;

  ////////////////////////////////////////////////////////////////////////////
  // 9-bit adders wrap naturally, which gives the modulo range for free
  always_comb begin
    delay_next = delay_reg;
    if (req_i.valid) begin
      case (req_i.cmd)
        SIDR_CMD_UP: delay_next = delay_reg + SIDR_ONE_TAP;
        SIDR_CMD_DOWN: delay_next = delay_reg - SIDR_ONE_TAP;
        SIDR_CMD_CUP: delay_next = delay_reg + coarse_step_i;
        SIDR_CMD_CDOWN: delay_next = delay_reg - coarse_step_i;
        default: delay_next = req_i.value;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_reg <= SIDR_DLY_RESET;
    end else begin
      delay_reg <= delay_next;
    end
  end

  assign delay_o = delay_reg;

endmodule : sidr_delay_engine
`default_nettype wire

// >>> hw/sidr_bank.sv
// sidr_bank: wishbone register bank for the slice 3 and slice 4 input delays.
// assumes: classic wishbone master on clk_i; fabric loads use the same clock.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module sidr_bank
  import sidr_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fabric_load_i,
  input wire logic [SIDR_BUS_W-1:0] fabric_tap_count_in_i,
  output logic [SIDR_BUS_W-1:0] fabric_tap_count_out_o
);

  initial begin
    // word_index reads address bits 9:2, so narrower buses cannot be served
    if (ADDR_W < 10 || ADDR_W > 32) begin
      $error("sidr_bank: ADDR_W must lie in 10..32");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] adr);
    word_index = adr[9:2];
  endfunction : word_index

  function automatic sidr_req_s make_req(input logic [31:0] d, input logic lo, input logic hi);
    sidr_req_s r;
    r.valid = 1'b1;
    // a command needs the high lane; a load needs lanes 0 and 1, and with only the low lane nothing is written
    r.cmd = hi ? sidr_cmd_e'({d[SIDR_COARSE_BIT], d[SIDR_DOWN_BIT], d[SIDR_UP_BIT]})
               : SIDR_CMD_LOAD0;
    r.value = d[8:0];
    if (!lo) begin
      r.valid = hi && (r.cmd != SIDR_CMD_LOAD0) && (r.cmd != SIDR_CMD_LOAD3)
                && (r.cmd != SIDR_CMD_LOAD4) && (r.cmd != SIDR_CMD_LOAD7);
    end
    make_req = r;
  endfunction : make_req

  logic req_live;
  logic wr_take;
  logic [7:0] idx;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [8:0] coarse_reg;
  logic fabric_en_reg;
  logic [8:0] slice3_delay_value;
  logic [8:0] slice4_delay_value;
  sidr_req_s req3;
  sidr_req_s req4;
  logic [SIDR_BUS_W-1:0] tap_out_reg;

  // one wait-free answer: ack the cycle after the request, then drop it
  assign req_live = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_take = req_live && wb_we_i;
  assign idx = word_index(wb_adr_i);

  ////////////////////////////////////////////////////////////////////////////
  // ack and read data

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_live;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= SIDR_UNMAPPED_DATA;
    end else if (req_live) begin
      case (idx)
        SIDR_IDX_SLICE3: rdata_reg <= {23'h00_0000, slice3_delay_value};
        SIDR_IDX_SLICE4: rdata_reg <= {23'h00_0000, slice4_delay_value};
        SIDR_IDX_COARSE_STEP: rdata_reg <= {23'h00_0000, coarse_reg};
        SIDR_IDX_FABRIC_CTRL: rdata_reg <= {31'h0000_0000, fabric_en_reg};
        default: rdata_reg <= SIDR_UNMAPPED_DATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_reg <= SIDR_COARSE_RESET;
    end else if (wr_take && idx == SIDR_IDX_COARSE_STEP && wb_sel_i[0]) begin
      coarse_reg <= wb_dat_i[8:0];
    end
  end

  // fabric loads are off after reset so software owns the delays first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fabric_en_reg <= 1'b0;
    end else if (wr_take && idx == SIDR_IDX_FABRIC_CTRL && wb_sel_i[0]) begin
      fabric_en_reg <= wb_dat_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // update requests; a bus write to a slice wins over a fabric load of that slice in the same cycle

  always_comb begin
    req3 = '0;
    req4 = '0;
    if (wr_take && idx == SIDR_IDX_SLICE3) begin
      req3 = make_req(wb_dat_i, wb_sel_i[0] & wb_sel_i[1], wb_sel_i[1]);
    end else if (fabric_en_reg && fabric_load_i) begin
      req3.valid = 1'b1;
      req3.cmd = SIDR_CMD_LOAD0;
      req3.value = fabric_tap_count_in_i[SIDR_BUS_LO_SLICE3 +: SIDR_DLY_W];
    end
    if (wr_take && idx == SIDR_IDX_SLICE4) begin
      req4 = make_req(wb_dat_i, wb_sel_i[0] & wb_sel_i[1], wb_sel_i[1]);
    end else if (fabric_en_reg && fabric_load_i) begin
      req4.valid = 1'b1;
      req4.cmd = SIDR_CMD_LOAD0;
      req4.value = fabric_tap_count_in_i[SIDR_BUS_LO_SLICE4 +: SIDR_DLY_W];
    end
  end

  sidr_delay_engine u_slice3 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req3),
    .coarse_step_i(coarse_reg),
    .delay_o(slice3_delay_value)
  );

  sidr_delay_engine u_slice4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req4),
    .coarse_step_i(coarse_reg),
    .delay_o(slice4_delay_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fabric view; registered, so it trails the stored value by one cycle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_out_reg <= '0;
    end else begin
      tap_out_reg <= '0;
      tap_out_reg[SIDR_BUS_LO_SLICE3 +: SIDR_DLY_W] <= slice3_delay_value;
      tap_out_reg[SIDR_BUS_LO_SLICE4 +: SIDR_DLY_W] <= slice4_delay_value;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign fabric_tap_count_out_o = tap_out_reg;

endmodule : sidr_bank
`default_nettype wire

// >>> tb/sidr_bank_props.sv
// sidr_bank_props: port-level checks of the slice delay register bank.
// assumes: bound into sidr_bank; fabric loads idle during slice writes.
`timescale 1ns/100ps
`default_nettype none
module sidr_bank_props
  import sidr_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fabric_load_i,
  input wire logic [SIDR_BUS_W-1:0] fabric_tap_count_in_i,
  input wire logic [SIDR_BUS_W-1:0] fabric_tap_count_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic w3;
  logic w4;
  logic [2:0] c;
  logic [8:0] o3;
  logic [8:0] o4;
  // command order is coarse, down, up = bits 13, 14, 15
  assign c = {wb_dat_i[13], wb_dat_i[14], wb_dat_i[15]};
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign w3 = tk & wb_we_i & (wb_adr_i[9:2] == SIDR_IDX_SLICE3) & (wb_sel_i == 4'hf);
  assign w4 = tk & wb_we_i & (wb_adr_i[9:2] == SIDR_IDX_SLICE4) & (wb_sel_i == 4'hf);
  assign o3 = fabric_tap_count_out_o[35:27];
  assign o4 = fabric_tap_count_out_o[44:36];
  ////////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (tk |=> wb_ack_o) else $error("request not answered");
  rd3_match_a: assert property (tk && !wb_we_i && wb_adr_i[9:2] == SIDR_IDX_SLICE3
    |=> wb_dat_o[8:0] == o3) else $error("slice3 read differs from tap bus");
  rd4_match_a: assert property (tk && !wb_we_i && wb_adr_i[9:2] == SIDR_IDX_SLICE4
    |=> wb_dat_o[8:0] == o4) else $error("slice4 read differs from tap bus");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:9] == '0)
    else $error("upper read bits not zero");
  up3_step_a: assert property (w3 && c == 3'b001 |-> ##2 o3 == $past(o3, 2) + 9'h001)
    else $error("slice3 step up wrong");
  dn3_step_a: assert property (w3 && c == 3'b010 |-> ##2 o3 == $past(o3, 2) - 9'h001)
    else $error("slice3 step down wrong");
  ld3_value_a: assert property (w3 && c inside {3'b000, 3'b011, 3'b100, 3'b111}
    |-> ##2 o3 == $past(wb_dat_i[8:0], 2)) else $error("slice3 load wrong");
  ld4_value_a: assert property (w4 && c == 3'b000 |-> ##2 o4 == $past(wb_dat_i[8:0], 2))
    else $error("slice4 load wrong");
  bus_spare_a: assert property (fabric_tap_count_out_o[26:0] == '0)
    else $error("unused tap bus bits set");
  cover property (w3 && c == 3'b001);
  cover property (w4);
  cover property (tk && !wb_we_i);
endmodule : sidr_bank_props
bind sidr_bank sidr_bank_props #(.ADDR_W(ADDR_W)) i_sidr_bank_props (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .fabric_load_i(fabric_load_i),
  .fabric_tap_count_in_i(fabric_tap_count_in_i),
  .fabric_tap_count_out_o(fabric_tap_count_out_o));
`default_nettype wire

// >>> tb/sidr_bank_test.sv
// sidr_bank_test: register-sequence bench for the slice delay bank.
// assumes: default ADDR_W, coarse step reset as the package states.
`timescale 1ns/100ps
`default_nettype none
module sidr_bank_test
  import sidr_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, fl = 0;
  logic [9:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat, got;
  logic [44:0] fin = 0, fout;
  int n_mismatch = 0, checked = 0, cyc_n = 0;
  sidr_bank i_sidr_bank (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .fabric_load_i(fl), .fabric_tap_count_in_i(fin),
    .fabric_tap_count_out_o(fout));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // request held until ack edge, released right after it
  task bus(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    got = rdat;
    cyc <= 0; stb <= 0;
  endtask : bus
  task wr(input logic [9:0] a, input logic [31:0] d);
    bus(1, a, 4'hf, d);
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] e);
    bus(0, a, 4'hf, 0);
    chk("register", e, got);
  endtask : rd
  // read a slice and compare both register and tap bus
  task rs(input int n, input logic [8:0] e);
    rd(n ? 10'h058 : 10'h054, {23'h0, e});
    chk("tap bus", {23'h0, e}, 32'((fout >> (n ? 36 : 27)) & 45'h1ff));
  endtask : rs
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rs(0, 9'h000);
    rs(1, 9'h000);
    rd(10'h080, 32'h0000_0008);
    rd(10'h084, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) if (i inside {0, 3, 4, 7}) begin
      wr(10'h054, {16'h0, i[0], i[1], i[2], 4'hf, 9'(9'h0a0 + i)});
      rs(0, 9'(9'h0a0 + i));
    end
    $display("test load done");
    wr(10'h054, 32'h0000_01ff);
    wr(10'h054, 32'h0000_8055);
    rs(0, 9'h000);
    wr(10'h054, 32'h0000_4000);
    rs(0, 9'h1ff);
    wr(10'h080, 32'h0000_000a);
    wr(10'h054, 32'h0000_01fa);
    wr(10'h054, 32'h0000_a000);
    rs(0, 9'h004);
    wr(10'h054, 32'h0000_6000);
    rs(0, 9'h1fa);
    wr(10'h054, 32'h0000_0003);
    wr(10'h054, 32'h0000_6000);
    rs(0, 9'h1f9);
    $display("test step done");
    wr(10'h058, 32'h0000_0123);
    wr(10'h058, 32'h0000_8000);
    rs(1, 9'h124);
    rs(0, 9'h1f9);
    bus(1, 10'h054, 4'h1, 32'h0000_8000);
    rs(0, 9'h1f9);
    wr(10'h3fc, 32'h0000_ffff);
    rd(10'h3fc, 32'h0000_0000);
    $display("test slice4 done");
    fin <= {9'h0aa, 9'h055, 27'h0};
    fl <= 1;
    rs(0, 9'h1f9);
    wr(10'h084, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    fl <= 0;
    rs(0, 9'h055);
    rs(1, 9'h0aa);
    $display("test fabric done");
    finish_test();
  end
endmodule : sidr_bank_test
`default_nettype wire
